/* File: hdl/sysref_capture.v */
`timescale 1ns/1ps
`include "sysref_sync_regs.vh"
module sysref_capture (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // reference pin
    input wire sysref_in,
    // register port
    input wire reg_wr,
    input wire reg_rd,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    output reg [7:0] reg_rdata,
    // configuration from the rest of the chip
    input wire [3:0] ignore_count,
    input wire [1:0] clk_div_sel,
    input wire [7:0] lmfc_period_m1,
    input wire decim_on,
    // results
    output reg realign,
    output reg resync_req,
    output reg [2:0] ctrl_bits,
    output reg sysref_captured,
    output reg [2:0] div_phase,
    output reg [7:0] lmfc_phase
);

    // selector match decode, used for each control bit
    function fn_is_ts;
        input [2:0] sel;
        begin
            fn_is_ts = (sel == `FN_SYSREF);
        end
    endfunction

    reg rst_s1_ff, rst_s2_ff;
    wire rst_n;
    reg sr_s1_ff, sr_s2_ff, sr_prev_ff;
    reg [7:0] chip_sync_ff, sr_ctrl_ff, sr_win_ff, sr_tsdly_ff;
    reg [7:0] cb_fn01_ff, cb_fn2_ff, cs_cnt_ff;
    reg [3:0] setup_stat_ff, hold_stat_ff;
    reg [3:0] pre_run_ff, post_run_ff;
    reg post_act_ff, ev_d_ff;
    reg [4:0] ign_ff;
    reg [7:0] ts_cnt_ff;
    reg ts_busy_ff;
    wire [1:0] mode;
    wire rise_ev, fall_ev, raw_ev, ev;
    wire ts_mode;
    wire in_win;
    wire act;
    wire [2:0] div_max;
    wire [8:0] win_lo;
    wire [7:0] nxt_lmfc_phase;
    reg ts_mark;

    // reset release through two flops
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    // pin synchroniser; prev copy taken from the second stage only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sr_s1_ff <= 1'b0;
            sr_s2_ff <= 1'b0;
            sr_prev_ff <= 1'b0;
        end else begin
            sr_s1_ff <= sysref_in;
            sr_s2_ff <= sr_s1_ff;
            sr_prev_ff <= sr_s2_ff;
        end
    end

    assign mode = sr_ctrl_ff[`POS_MODE_HI:`POS_MODE_LO];
    assign ts_mode = chip_sync_ff[`POS_SYNC_MODE];
    // transition qualified on the clock
    assign rise_ev = sr_s2_ff & ~sr_prev_ff;
    assign fall_ev = ~sr_s2_ff & sr_prev_ff;
    assign raw_ev = sr_ctrl_ff[`POS_TRANS] ? fall_ev : rise_ev;
    // alternate capture edge modelled as the event registered one clock cycle later
    assign ev = sr_ctrl_ff[`POS_CLK_EDGE] ? ev_d_ff : raw_ev;

    // skew window around multiframe phase 0
    assign win_lo = {1'b0, lmfc_period_m1} + 9'h001
        - {7'h00, sr_win_ff[3:2]};
    // phase the multiframe counter reaches at the capture edge; judging
    // that value keeps a realigned counter and a periodic reference on the
    // same count, so an aligned reference never forces a resync
    assign nxt_lmfc_phase = (lmfc_phase >= lmfc_period_m1) ? 8'h00
        : lmfc_phase + 8'h01;
    assign in_win = (nxt_lmfc_phase == 8'h00)
        || (nxt_lmfc_phase <= {6'h00, sr_win_ff[1:0]})
        || ({1'b0, nxt_lmfc_phase} >= win_lo);

    // qualifying event in the armed mode
    assign act = ev && ((mode == `MODE_CONT)
        || (mode == `MODE_NSHOT && ign_ff == 5'h00));

    // divide ratio 1, 2, 4 or 8
    assign div_max = (clk_div_sel == 2'h0) ? 3'h0 :
                     (clk_div_sel == 2'h1) ? 3'h1 :
                     (clk_div_sel == 2'h2) ? 3'h3 : 3'h7;

    // register writes; a software write wins over the self clear
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chip_sync_ff <= `RST_CHIP_SYNC;
            sr_ctrl_ff <= `RST_SR_CTRL;
            sr_win_ff <= `RST_SR_WIN;
            sr_tsdly_ff <= `RST_SR_TSDLY;
            cb_fn01_ff <= `RST_CB_FN;
            cb_fn2_ff <= `RST_CB_FN;
            cs_cnt_ff <= `RST_CS_CNT;
        end else if (reg_wr) begin
            case (reg_addr)
                `OFS_CHIP_SYNC: chip_sync_ff <= {7'h00, reg_wdata[0]};
                `OFS_SR_CTRL: sr_ctrl_ff <= {3'h0, reg_wdata[4:1], 1'b0};
                `OFS_SR_WIN: sr_win_ff <= {4'h0, reg_wdata[3:0]};
                `OFS_SR_TSDLY: sr_tsdly_ff <= reg_wdata;
                `OFS_CB_FN01: cb_fn01_ff <= {1'b0, reg_wdata[6:4], 1'b0,
                    reg_wdata[2:0]};
                `OFS_CB_FN2: cb_fn2_ff <= {5'h00, reg_wdata[2:0]};
                `OFS_CS_CNT: cs_cnt_ff <= {reg_wdata[7:6], 6'h00};
                default: ;
            endcase
        end else if (act && mode == `MODE_NSHOT) begin
            sr_ctrl_ff[`POS_MODE_HI:`POS_MODE_LO] <= `MODE_OFF;
        end
    end

    // ignore counter armed by each nonzero mode write
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ign_ff <= 5'h00;
            ev_d_ff <= 1'b0;
        end else begin
            ev_d_ff <= raw_ev;
            if (reg_wr && reg_addr == `OFS_SR_CTRL
                && reg_wdata[2:1] != `MODE_OFF)
                ign_ff <= {1'b0, ignore_count};
            else if (ev && mode == `MODE_NSHOT && ign_ff != 5'h00)
                ign_ff <= ign_ff - 5'h01;
        end
    end

    // realignment decision and divider / multiframe counters
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            realign <= 1'b0;
            resync_req <= 1'b0;
            div_phase <= 3'h0;
            lmfc_phase <= 8'h00;
        end else begin
            realign <= 1'b0;
            resync_req <= 1'b0;
            if (act && !ts_mode && (mode == `MODE_NSHOT || !in_win)) begin
                realign <= 1'b1;
                resync_req <= (mode == `MODE_CONT);
                div_phase <= 3'h0;
                lmfc_phase <= 8'h00;
            end else begin
                div_phase <= (div_phase >= div_max) ? 3'h0
                    : div_phase + 3'h1;
                lmfc_phase <= nxt_lmfc_phase;
            end
        end
    end

    // timestamp delay: count down then mark one sample
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ts_busy_ff <= 1'b0;
            ts_cnt_ff <= 8'h00;
        end else if (act && ts_mode) begin
            ts_busy_ff <= (sr_tsdly_ff != 8'h00);
            ts_cnt_ff <= sr_tsdly_ff;
        end else if (ts_busy_ff) begin
            ts_cnt_ff <= ts_cnt_ff - 8'h01;
            if (ts_cnt_ff == 8'h01)
                ts_busy_ff <= 1'b0;
        end
    end

    // the marked sample: immediate when no delay, else at count end
    always @* begin
        ts_mark = (act && ts_mode && sr_tsdly_ff == 8'h00)
            || (ts_busy_ff && ts_cnt_ff == 8'h01);
    end

    // control bit routing, allocated from bit 2 downward
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_cb
            wire [2:0] sel;
            wire used;
            // lowest control-bit count that enables this bit
            localparam [2:0] need = 3 - gi;
            if (gi == 2) begin : g_b2
                assign sel = cb_fn2_ff[2:0];
            end else begin : g_b01
                assign sel = cb_fn01_ff[gi*4+2:gi*4];
            end
            assign used = ({1'b0, cs_cnt_ff[`POS_CS_HI:`POS_CS_LO]}
                >= need);
            always @(posedge clk or negedge rst_n) begin
                if (!rst_n)
                    ctrl_bits[gi] <= 1'b0;
                else
                    ctrl_bits[gi] <= ts_mark && used && fn_is_ts(sel)
                        && !decim_on;
            end
        end
    endgenerate

    // setup/hold detectors around the capture point
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pre_run_ff <= 4'h0;
            post_run_ff <= 4'h0;
            post_act_ff <= 1'b0;
            setup_stat_ff <= 4'h0;
            hold_stat_ff <= 4'h0;
            sysref_captured <= 1'b0;
        end else begin
            // run length of the old level before the edge
            if (raw_ev)
                pre_run_ff <= 4'h0;
            else if (sr_s2_ff == sr_prev_ff && pre_run_ff != `MON_SAT)
                pre_run_ff <= pre_run_ff + 4'h1;
            if (raw_ev) begin
                setup_stat_ff <= pre_run_ff;
                post_act_ff <= 1'b1;
                post_run_ff <= 4'h0;
                sysref_captured <= 1'b1;
            end else if (post_act_ff) begin
                if (sr_s2_ff != sr_prev_ff) begin
                    post_act_ff <= 1'b0;
                    hold_stat_ff <= 4'h0 - post_run_ff;
                end else if (post_run_ff == 4'h7) begin
                    post_act_ff <= 1'b0;
                    hold_stat_ff <= `MON_SAT;
                end else begin
                    post_run_ff <= post_run_ff + 4'h1;
                end
            end
        end
    end

    // register reads; unmapped offsets return zero
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `OFS_CHIP_SYNC: reg_rdata <= chip_sync_ff;
                `OFS_SR_CTRL: reg_rdata <= sr_ctrl_ff;
                `OFS_SR_WIN: reg_rdata <= sr_win_ff;
                `OFS_SR_TSDLY: reg_rdata <= sr_tsdly_ff;
                `OFS_SR_MON: reg_rdata <= {hold_stat_ff, setup_stat_ff};
                `OFS_CB_FN01: reg_rdata <= cb_fn01_ff;
                `OFS_CB_FN2: reg_rdata <= cb_fn2_ff;
                `OFS_CS_CNT: reg_rdata <= cs_cnt_ff;
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule // sysref_capture

/* File: hdl/sysref_sync_regs.vh */
`ifndef SYSREF_SYNC_REGS_VH
`define SYSREF_SYNC_REGS_VH
// register offsets
`define OFS_CHIP_SYNC 12'h1ff
`define OFS_SR_CTRL 12'h120
`define OFS_SR_WIN 12'h122
`define OFS_SR_TSDLY 12'h123
`define OFS_SR_MON 12'h128
`define OFS_CB_FN01 12'h559
`define OFS_CB_FN2 12'h55a
`define OFS_CS_CNT 12'h58f
// field positions
`define POS_SYNC_MODE 0
`define POS_MODE_LO 1
`define POS_MODE_HI 2
`define POS_CLK_EDGE 3
`define POS_TRANS 4
`define POS_CS_LO 6
`define POS_CS_HI 7
// reset values
`define RST_CHIP_SYNC 8'h00
`define RST_SR_CTRL 8'h00
`define RST_SR_WIN 8'h00
`define RST_SR_TSDLY 8'h00
`define RST_CB_FN 8'h00
`define RST_CS_CNT 8'h00
// encodings and counts
`define MODE_OFF 2'h0
`define MODE_CONT 2'h1
`define MODE_NSHOT 2'h2
`define FN_SYSREF 3'h5
`define MON_SAT 4'h8
`endif

/* File: verif/sysref_capture_assertions.sv */
`timescale 1ns/1ps
module sysref_capture_assertions (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // observed ports
    input wire reg_rd,
    input wire [11:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire decim_on,
    input wire realign,
    input wire resync_req,
    input wire [2:0] ctrl_bits,
    input wire sysref_captured,
    input wire [2:0] div_phase,
    input wire [7:0] lmfc_phase
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // read of an address outside the map
    sequence s_unmapped_rd;
        reg_rd && reg_addr == 12'h7ff;
    endsequence
    // decimation held across the mark slot
    sequence s_decim_held;
        decim_on ##1 decim_on;
    endsequence
    a_realign_zero_phase: assert property (realign |->
        div_phase == 3'h0 && lmfc_phase == 8'h00) else $error("phase not zero");
    a_resync_with_realign: assert property (resync_req |-> realign)
        else $error("resync without realign");
    a_realign_one_cycle: assert property (realign |=> !realign)
        else $error("realign longer than one cycle");
    a_capture_flag_sticky: assert property ($rose(sysref_captured) |=>
        sysref_captured[*8]) else $error("capture flag dropped");
    a_realign_needs_capture: assert property (realign |-> sysref_captured)
        else $error("realign without capture");
    a_decim_no_mark: assert property (s_decim_held |-> ctrl_bits == 3'h0)
        else $error("mark while decimating");
    a_mark_one_cycle: assert property (ctrl_bits != 3'h0 |=>
        ctrl_bits == 3'h0) else $error("mark longer than one cycle");
    a_mark_no_realign: assert property (ctrl_bits != 3'h0 |-> !realign)
        else $error("realign in timestamp mode");
    a_unmapped_read_zero: assert property (s_unmapped_rd |=>
        reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // sysref_capture_assertions
bind sysref_capture sysref_capture_assertions u_chk (
    .clk(clk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_rdata(reg_rdata), .decim_on(decim_on), .realign(realign),
    .resync_req(resync_req), .ctrl_bits(ctrl_bits),
    .sysref_captured(sysref_captured), .div_phase(div_phase),
    .lmfc_phase(lmfc_phase));

/* File: verif/sysref_src.sv */
`timescale 1ns/1ps
module sysref_src (
    // clock
    input wire clk,
    // pulse request
    input wire go,
    input wire [7:0] width,
    // reference pin
    output reg sysref_in = 1'b0
);
    reg [7:0] left_ff = 8'h00;
    // hold the pulse for its whole width, idle low between pulses
    always @(posedge clk) begin
        if (go) begin
            left_ff <= width;
            sysref_in <= 1'b1;
        end else if (left_ff > 8'h01) begin
            left_ff <= left_ff - 8'h01;
        end else begin
            left_ff <= 8'h00;
            sysref_in <= 1'b0;
        end
    end
endmodule // sysref_src

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
    reg clk = 1'b0;
    reg arst_n = 1'b0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [11:0] reg_addr = 12'h000;
    reg [7:0] reg_wdata = 8'h00;
    reg [3:0] ignore_count = 4'h0;
    reg decim_on = 1'b0;
    reg go = 1'b0;
    reg [7:0] width = 8'h10;
    wire sysref_in, realign, resync_req, sysref_captured;
    wire [7:0] reg_rdata, lmfc_phase;
    wire [2:0] ctrl_bits, div_phase;
    integer fail_count = 0;
    integer total_checks = 0;
    integer lat, lm, nre, nrs, i, k, base;
    reg [2:0] mk;
    reg [31:0] row;
    // divide by 8 and an 8-cycle multiframe
    reg [1:0] clk_div_sel = 2'h3;
    reg [7:0] lmfc_period_m1 = 8'h07;
    // offsets read back after reset; the last one is unmapped
    function [11:0] reset_addr(input integer n);
        case (n)
            0: reset_addr = 12'h1ff;
            1: reset_addr = 12'h120;
            2: reset_addr = 12'h122;
            3: reset_addr = 12'h123;
            4: reset_addr = 12'h559;
            5: reset_addr = 12'h55a;
            6: reset_addr = 12'h58f;
            default: reset_addr = 12'h7ff;
        endcase
    endfunction
    // cs field, selector address, selector value, expected marks
    function [31:0] ts_tab(input integer n);
        case (n)
            0: ts_tab = 32'h40_55a_05_4;
            1: ts_tab = 32'h80_559_50_6;
            default: ts_tab = 32'hc0_559_05_5;
        endcase
    endfunction
    always #5 clk = ~clk;
    sysref_src u_src (.clk(clk), .go(go), .width(width),
        .sysref_in(sysref_in));
    sysref_capture dut (.clk(clk), .arst_n(arst_n), .sysref_in(sysref_in),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ignore_count(ignore_count), .clk_div_sel(clk_div_sel),
        .lmfc_period_m1(lmfc_period_m1), .decim_on(decim_on),
        .realign(realign),
        .resync_req(resync_req), .ctrl_bits(ctrl_bits),
        .sysref_captured(sysref_captured), .div_phase(div_phase),
        .lmfc_phase(lmfc_phase));
    task check(input [15:0] seen, input [15:0] exp, input string what);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wr(input [11:0] a, input [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [11:0] a, input [7:0] exp, input string what);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        #1 check({8'h00, reg_rdata}, {8'h00, exp}, what);
    endtask
    // fixed spacing: go edges are 63 + gap cycles apart
    task pulse(input integer gap, input [7:0] win);
        lat = -1;
        lm = -1;
        nre = 0;
        nrs = 0;
        mk = 3'h0;
        repeat (gap) @(posedge clk);
        wr(12'h122, win);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (i = 0; i < 60; i = i + 1) begin
            @(posedge clk);
            #1;
            if (realign === 1'b1 && lat < 0) lat = i;
            if (realign === 1'b1) nre = nre + 1;
            if (resync_req === 1'b1) nrs = nrs + 1;
            if (ctrl_bits != 3'h0 && lm < 0) lm = i;
            mk = mk | ctrl_bits;
        end
    endtask
    task t_reset;
        for (k = 0; k < 8; k = k + 1)
            rd(reset_addr(k), 8'h00, "reset value");
        check({15'h0000, sysref_captured}, 16'h0000, "captured");
    endtask
    task t_ignore;
        @(posedge clk);
        ignore_count <= 4'h2;
        wr(12'h120, 8'h04);
        for (k = 0; k < 4; k = k + 1) begin
            pulse(1, 8'h00);
            check(nre[15:0], {15'h0000, k == 2}, "nshot count");
        end
        rd(12'h120, 8'h00, "mode cleared");
    endtask
    task t_edges;
        @(posedge clk);
        ignore_count <= 4'h0;
        wr(12'h120, 8'h04);
        pulse(1, 8'h00);
        base = lat;
        check(nre[15:0], 16'h0001, "rising capture");
        check({15'h0000, sysref_captured}, 16'h0001, "captured");
        rd(12'h128, 8'h88, "monitor");
        wr(12'h120, 8'h14);
        pulse(1, 8'h00);
        check(lat[15:0], base[15:0] + 16'h0010, "falling lat");
        wr(12'h120, 8'h0c);
        pulse(1, 8'h00);
        check(lat[15:0], base[15:0] + 16'h0001, "edge lat");
    endtask
    task t_cont;
        wr(12'h120, 8'h02);
        pulse(1, 8'h00);
        pulse(1, 8'h00);
        check({nre[7:0], nrs[7:0]}, 16'h0000, "aligned");
        pulse(5, 8'h00);
        check({nre[7:0], nrs[7:0]}, 16'h0101, "offset four");
        pulse(3, 8'h0f);
        check(nre[15:0], 16'h0000, "inside window");
        pulse(3, 8'h0f);
        check({nre[7:0], nrs[7:0]}, 16'h0101, "outside window");
        wr(12'h120, 8'h00);
    endtask
    task t_stamp;
        wr(12'h1ff, 8'h01);
        for (k = 0; k < 3; k = k + 1) begin
            row = ts_tab(k);
            wr(12'h58f, row[31:24]);
            wr(row[23:12], row[11:4]);
            wr(12'h120, 8'h04);
            pulse(1, 8'h00);
            base = lm;
            check({nre[12:0], mk}, {13'h0000, row[2:0]}, "mark");
        end
        @(posedge clk);
        decim_on <= 1'b1;
        wr(12'h120, 8'h04);
        pulse(1, 8'h00);
        check({13'h0000, mk}, 16'h0000, "decim mark");
        @(posedge clk);
        decim_on <= 1'b0;
        // a delay of three moves the mark three samples later
        wr(12'h123, 8'h03);
        wr(12'h120, 8'h04);
        pulse(1, 8'h00);
        check(lm[15:0], base[15:0] + 16'h0003, "mark delay");
    endtask
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_ignore();
        t_edges();
        t_cont();
        t_stamp();
        stop_test();
    end
endmodule // tb
